// ==== core/serdes_link_pkg.sv ====
// Shared constants and types for the serial link coding control block.
package serdes_link_pkg;

    // Register map, byte addresses.
    localparam logic [11:0] CTRL_ADDR    = 12'h608;
    localparam logic [11:0] STATUS_ADDR  = 12'h610;
    localparam logic [11:0] RESTART_ADDR = 12'h614;

    // Control register image; member order equals bit order 15 down to 0.
    typedef struct packed {
        logic       tx_err_dis;
        logic       idx_force;
        logic [3:0] idx_value;
        logic       link_en;
        logic       rx_pol_inv;
        logic       tx_pol_inv;
        logic [1:0] rx_order;
        logic       tx_order;
        logic       pkt_align;
        logic [1:0] an_timer;
        logic       negotiation_enable;
    } serdes_ctrl_s;

    localparam logic [15:0] CTRL_RESET    = 16'h007b;
    localparam int          LINK_EN_BIT   = 9;
    localparam int          RESTART_BIT   = 6;

    // Status register field positions.
    localparam int          ST_IDX_LSB    = 4;
    localparam int          ST_SYNC_BIT   = 8;
    localparam int          ST_ANDONE_BIT = 10;
    localparam int          ST_LINKUP_BIT = 11;

    // Link timer codes and lengths.
    localparam logic [1:0]  AN_T_1600US   = 2'h0;
    localparam logic [1:0]  AN_T_2US      = 2'h1;
    localparam logic [1:0]  AN_T_800US    = 2'h2;
    localparam logic [1:0]  AN_T_11MS     = 2'h3;
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          T_1600US_NS   = 1600000;
    localparam int          T_2US_NS      = 2000;
    localparam int          T_800US_NS    = 800000;
    localparam int          T_11MS_NS     = 11000000;
    localparam int          CYC_1600US    = (T_1600US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CYC_2US       = (T_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CYC_800US     = (T_800US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CYC_11MS      = (T_11MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TIMER_W       = 21;

    // Word alignment, transmit error code and strap wait count.
    localparam int          WORD_W        = 10;
    localparam int          IDX_COUNT     = 10;
    localparam logic [6:0]  COMMA_POS     = 7'h1f;
    localparam logic [6:0]  COMMA_NEG     = 7'h60;
    localparam logic [1:0]  SYNC_COMMAS   = 2'h3;
    localparam logic [9:0]  ERR_CODE      = 10'h2e8;
    localparam logic [1:0]  STRAP_WAIT    = 2'h3;

endpackage

// ==== core/serdes_link_ctrl.sv ====
// Serial link coding control: register, word alignment, bit ordering and negotiation timer.
`timescale 1ns/1ps
// How it works
// [R1] Set bit drops transmit error indication from MAC.
// [R2] Force bit replaces automatically found boundary index.
// [R3] Four-bit software index, reset zero, picks boundary.
// [R4] Link runs only when enable set; strap-reset.
// [R5] Receive polarity bit inverts every received bit.
// [R6] Transmit polarity bit inverts every sent bit.
// [R7] Two bits order incoming words and bus halves.
// [R8] One bit reverses transmitted word bit order.
// [R9] Packet start waits for even slot when set.
// [R10] Two-bit code picks negotiation link timer length.
// [R11] Negotiation enable runs or skips auto-negotiation.
// [R12] Control register resets to 0x7b, all writable.
// [R13] Status shows boundary index in use, forced or alignment-chosen, read-only.
// [R14] Self-clearing bit restarts auto-negotiation.
module serdes_link_ctrl #(
    parameter int unsigned CYC_1600US = serdes_link_pkg::CYC_1600US,
    parameter int unsigned CYC_800US  = serdes_link_pkg::CYC_800US,
    parameter int unsigned CYC_11MS   = serdes_link_pkg::CYC_11MS
) (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RESET_IN,
    // APB slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic             PREADY_OUT,
    output logic [31:0]      PRDATA_OUT,
    output logic             PSLVERR_OUT,
    // Strap pin
    input  wire logic        STRAP_LINK_EN_IN,
    // Deserializer side
    input  wire logic [9:0]  RX_WORD_IN,
    output logic [9:0]       RX_CODE_OUT,
    output logic             RX_VALID_OUT,
    // Transmit coding side
    input  wire logic [9:0]  TX_CODE_IN,
    input  wire logic        TX_EN_IN,
    input  wire logic        TX_ERR_IN,
    output logic [9:0]       TX_WORD_OUT,
    // Link state
    output logic             LINK_UP_OUT,
    output logic             AN_COMPLETE_OUT
);

    typedef enum logic {ALN_SEARCH, ALN_LOCKED} align_state_e;
    typedef enum logic [1:0] {AN_IDLE, AN_TIMING, AN_DONE} an_state_e;

    // Bus decode.
    wire        setup_hit  = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
    wire        access_end = PSEL_IN & PENABLE_IN & PREADY_OUT;
    wire        hit_ctrl   = PADDR_IN == serdes_link_pkg::CTRL_ADDR;
    wire        hit_status = PADDR_IN == serdes_link_pkg::STATUS_ADDR;
    wire        hit_rst    = PADDR_IN == serdes_link_pkg::RESTART_ADDR;
    wire        mapped     = hit_ctrl | hit_status | hit_rst;
    wire        wr_ctrl    = access_end & PWRITE_IN & hit_ctrl;
    wire        wr_restart = access_end & PWRITE_IN & hit_rst & PWDATA_IN[serdes_link_pkg::RESTART_BIT];

    serdes_link_pkg::serdes_ctrl_s ctrl_reg;
    logic [15:0]  ctrl_bits;
    logic [15:0]  status_bits;
    logic [15:0]  wdata16;
    logic [31:0]  rdata_next;
    logic         strap_meta_reg;
    logic         strap_sync_reg;
    logic [1:0]   strap_cnt_reg;
    logic         restart_reg;

    assign ctrl_bits = ctrl_reg;
    assign wdata16   = PWDATA_IN[15:0];

    // Strap passes two flops; the enable is taken only after they have settled past reset.
    always_ff @(posedge CLK_IN) begin
        strap_meta_reg <= STRAP_LINK_EN_IN;
        strap_sync_reg <= strap_meta_reg;
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            ctrl_reg      <= serdes_link_pkg::CTRL_RESET; // R12
            strap_cnt_reg <= 2'h0;
            restart_reg   <= 1'b0;
        end else begin
            restart_reg <= wr_restart; // R14
            if (strap_cnt_reg != serdes_link_pkg::STRAP_WAIT) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
            if (wr_ctrl) begin
                ctrl_reg <= wdata16; // R12
            end else if (strap_cnt_reg == serdes_link_pkg::STRAP_WAIT - 2'h1) begin
                ctrl_reg.link_en <= strap_sync_reg; // R4
            end
        end
    end

    // Receive path: polarity, then per-word bit order.
    logic [9:0] rx_pol;
    logic [9:0] rx_ord;
    logic [9:0] prev_word_reg;
    logic [19:0] comma_bus;
    assign rx_pol = ctrl_reg.rx_pol_inv ? ~RX_WORD_IN : RX_WORD_IN; // R5

    genvar b;
    generate
        for (b = 0; b < serdes_link_pkg::WORD_W; b++) begin : g_rev
            assign rx_ord[b] = ctrl_reg.rx_order[0] ? rx_pol[9 - b] : rx_pol[b]; // R7
        end
    endgenerate

    // The earlier word lands in the low or high half of the comma bus.
    assign comma_bus = ctrl_reg.rx_order[1] ? {prev_word_reg, rx_ord} : {rx_ord, prev_word_reg}; // R7

    logic [serdes_link_pkg::IDX_COUNT-1:0] comma_hit;
    logic [9:0] cand [serdes_link_pkg::IDX_COUNT];
    genvar i;
    generate
        for (i = 0; i < serdes_link_pkg::IDX_COUNT; i++) begin : g_idx
            assign cand[i]      = comma_bus[i +: 10];
            assign comma_hit[i] = (cand[i][9:3] == serdes_link_pkg::COMMA_POS) |
                                  (cand[i][9:3] == serdes_link_pkg::COMMA_NEG);
        end
    endgenerate

    // Lowest hit index wins when several offsets look like a comma.
    logic [3:0] first_hit;
    logic       any_hit;
    always_comb begin
        first_hit = 4'h0;
        any_hit   = 1'b0;
        for (int k = serdes_link_pkg::IDX_COUNT - 1; k >= 0; k--) begin
            if (comma_hit[k]) begin
                first_hit = 4'(k);
                any_hit   = 1'b1;
            end
        end
    end

    align_state_e align_state_reg;
    logic [3:0]   auto_idx_reg;
    logic [1:0]   comma_cnt_reg;
    logic         sync_reg;
    wire  [3:0]   use_idx  = ctrl_reg.idx_force ? ctrl_reg.idx_value : auto_idx_reg; // R2 R3
    wire          idx_ok   = use_idx < 4'(serdes_link_pkg::IDX_COUNT);
    wire  [9:0]   aligned  = idx_ok ? cand[use_idx] : 10'h000;
    wire          hit_here = idx_ok & comma_hit[use_idx];

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN || !ctrl_reg.link_en) begin
            align_state_reg <= ALN_SEARCH;
            auto_idx_reg    <= 4'h0;
            comma_cnt_reg   <= 2'h0;
            sync_reg        <= 1'b0;
            prev_word_reg   <= 10'h000;
        end else begin
            prev_word_reg <= rx_ord;
            case (align_state_reg)
                ALN_SEARCH: begin
                    if (ctrl_reg.idx_force ? hit_here : any_hit) begin // R2
                        if (!ctrl_reg.idx_force) begin
                            auto_idx_reg <= first_hit; // R13
                        end
                        comma_cnt_reg   <= 2'h1;
                        align_state_reg <= ALN_LOCKED;
                    end
                end
                ALN_LOCKED: begin
                    // A comma seen off the chosen boundary means the lock was wrong.
                    if (any_hit && !hit_here) begin
                        align_state_reg <= ALN_SEARCH;
                        comma_cnt_reg   <= 2'h0;
                        sync_reg        <= 1'b0;
                    end else if (hit_here && comma_cnt_reg != serdes_link_pkg::SYNC_COMMAS) begin
                        comma_cnt_reg <= comma_cnt_reg + 2'h1;
                        if (comma_cnt_reg == serdes_link_pkg::SYNC_COMMAS - 2'h1) begin
                            sync_reg <= 1'b1;
                        end
                    end
                end
                default: align_state_reg <= ALN_SEARCH;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            RX_CODE_OUT  <= 10'h000;
            RX_VALID_OUT <= 1'b0;
        end else begin
            RX_CODE_OUT  <= ctrl_reg.link_en ? aligned : 10'h000; // R4
            RX_VALID_OUT <= ctrl_reg.link_en & sync_reg; // R4
        end
    end

    // Transmit path: even-slot start, error substitution, bit order, polarity.
    logic       even_reg;
    logic       slip_reg;
    logic       en_d_reg;
    logic [9:0] code_d_reg;
    logic       err_d_reg;
    wire        pkt_start = TX_EN_IN & ~en_d_reg;
    // A packet that opens on an odd slot is carried one word late for its whole length.
    wire        slip_now  = pkt_start ? (ctrl_reg.pkt_align & ~even_reg) : (slip_reg & (TX_EN_IN | en_d_reg)); // R9
    wire  [9:0] tx_sel    = slip_now ? code_d_reg : TX_CODE_IN;
    wire        err_sel   = slip_now ? err_d_reg : TX_ERR_IN;
    wire  [9:0] tx_coded  = (err_sel & ~ctrl_reg.tx_err_dis) ? serdes_link_pkg::ERR_CODE : tx_sel; // R1
    logic [9:0] tx_ord;
    generate
        for (b = 0; b < serdes_link_pkg::WORD_W; b++) begin : g_txrev
            assign tx_ord[b] = ctrl_reg.tx_order ? tx_coded[9 - b] : tx_coded[b]; // R8
        end
    endgenerate

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            even_reg    <= 1'b1;
            slip_reg    <= 1'b0;
            en_d_reg    <= 1'b0;
            code_d_reg  <= 10'h000;
            err_d_reg   <= 1'b0;
            TX_WORD_OUT <= 10'h000;
        end else begin
            even_reg    <= ~even_reg;
            slip_reg    <= slip_now;
            en_d_reg    <= TX_EN_IN;
            code_d_reg  <= TX_CODE_IN;
            err_d_reg   <= TX_ERR_IN;
            if (!ctrl_reg.link_en) begin
                TX_WORD_OUT <= 10'h000; // R4
            end else begin
                TX_WORD_OUT <= ctrl_reg.tx_pol_inv ? ~tx_ord : tx_ord; // R6
            end
        end
    end

    // Negotiation: link timer runs once sync is held; restart reloads it.
    an_state_e          an_state_reg;
    logic [serdes_link_pkg::TIMER_W-1:0] timer_reg;
    logic [serdes_link_pkg::TIMER_W-1:0] timer_len;
    always_comb begin
        case (ctrl_reg.an_timer) // R10
            serdes_link_pkg::AN_T_1600US: timer_len = serdes_link_pkg::TIMER_W'(CYC_1600US);
            serdes_link_pkg::AN_T_2US:    timer_len = serdes_link_pkg::TIMER_W'(serdes_link_pkg::CYC_2US);
            serdes_link_pkg::AN_T_800US:  timer_len = serdes_link_pkg::TIMER_W'(CYC_800US);
            default:                      timer_len = serdes_link_pkg::TIMER_W'(CYC_11MS);
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN || !ctrl_reg.link_en || !sync_reg || restart_reg) begin // R14
            an_state_reg    <= AN_IDLE;
            timer_reg       <= '0;
            AN_COMPLETE_OUT <= 1'b0;
            LINK_UP_OUT     <= 1'b0;
        end else begin
            case (an_state_reg)
                AN_IDLE: begin
                    if (ctrl_reg.negotiation_enable) begin // R11
                        timer_reg    <= timer_len - 1'b1;
                        an_state_reg <= AN_TIMING;
                    end else begin
                        an_state_reg <= AN_DONE; // R11
                    end
                end
                AN_TIMING: begin
                    if (timer_reg == '0) begin
                        an_state_reg <= AN_DONE; // R10
                    end else begin
                        timer_reg <= timer_reg - 1'b1;
                    end
                end
                AN_DONE: begin
                    AN_COMPLETE_OUT <= ctrl_reg.negotiation_enable;
                    LINK_UP_OUT     <= 1'b1;
                end
                default: an_state_reg <= AN_IDLE;
            endcase
        end
    end

    // Status and read mux.
    always_comb begin
        status_bits = 16'h0000;
        status_bits[serdes_link_pkg::ST_IDX_LSB +: 4] = use_idx; // R13
        status_bits[serdes_link_pkg::ST_SYNC_BIT]     = sync_reg;
        status_bits[serdes_link_pkg::ST_ANDONE_BIT]   = AN_COMPLETE_OUT;
        status_bits[serdes_link_pkg::ST_LINKUP_BIT]   = LINK_UP_OUT;
        rdata_next = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_next[15:0] = ctrl_bits;
        end else if (hit_status) begin
            rdata_next[15:0] = status_bits;
        end
    end

    // Ready comes one cycle into the access phase so data and ready leave flops together.
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT  <= setup_hit;
            PSLVERR_OUT <= setup_hit & ~mapped;
            PRDATA_OUT  <= (setup_hit & ~PWRITE_IN) ? rdata_next : 32'h0000_0000;
        end
    end

endmodule // serdes_link_ctrl

// ==== tb/serdes_link_ctrl_assertions.sv ====
// Port-level checks for the serial link coding control block.
`timescale 1ns/1ps
module serdes_link_checker #(
    parameter int unsigned CYC_1600US = 40,
    parameter int unsigned CYC_800US  = 20,
    parameter int unsigned CYC_11MS   = 60
) (
    // Clock and reset
    input wire logic        CLK_IN,
    input wire logic        RESET_IN,
    // Register bus
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic        PREADY_OUT,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PSLVERR_OUT,
    // Link
    input wire logic        RX_VALID_OUT,
    input wire logic [9:0]  TX_WORD_OUT,
    input wire logic        LINK_UP_OUT,
    input wire logic        AN_COMPLETE_OUT
);
    // The 2 us code is a fixed count, so the shortest timer depends on the parameters.
    localparam int MIN_T = (CYC_800US < 250) ? int'(CYC_800US) : 250;
    logic [20:0] since_reg;
    wire         mapped = PADDR_IN == serdes_link_pkg::CTRL_ADDR || PADDR_IN == serdes_link_pkg::STATUS_ADDR
                          || PADDR_IN == serdes_link_pkg::RESTART_ADDR;
    wire         rd_restart = PREADY_OUT && !PWRITE_IN && PADDR_IN == serdes_link_pkg::RESTART_ADDR;

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) since_reg <= 21'h0;
        else if (since_reg != 21'h1fffff) since_reg <= since_reg + 21'h1;
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held past one cycle");
    a_ready_time: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
        else $error("access not answered in time");
    a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data outside answer");
    a_upper_zero: assert property (PREADY_OUT |-> PRDATA_OUT[31:16] == 16'h0)
        else $error("upper read data not zero");
    a_err_decode: assert property (PREADY_OUT |-> PSLVERR_OUT == !mapped)
        else $error("error flag disagrees with address");
    a_err_alone: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error flag without ready");
    a_restart_zero: assert property (rd_restart |-> PRDATA_OUT == 32'h0)
        else $error("restart bit read back nonzero");
    a_reset_quiet: assert property (disable iff (1'b0) RESET_IN |=> !PREADY_OUT && !RX_VALID_OUT
        && TX_WORD_OUT == 10'h0 && !LINK_UP_OUT && !AN_COMPLETE_OUT) else $error("outputs active after reset");
    a_timer_floor: assert property (AN_COMPLETE_OUT |-> since_reg >= MIN_T)
        else $error("negotiation done before timer");
    a_link_with_an: assert property ($rose(AN_COMPLETE_OUT) |-> ##[0:8] LINK_UP_OUT)
        else $error("link not up after negotiation");

    c_bus_error: cover property (PREADY_OUT && PSLVERR_OUT);
    c_sync: cover property ($rose(RX_VALID_OUT));
    c_an_done: cover property ($rose(AN_COMPLETE_OUT));
endmodule // serdes_link_checker

bind serdes_link_ctrl serdes_link_checker #(.CYC_1600US(CYC_1600US), .CYC_800US(CYC_800US), .CYC_11MS(CYC_11MS))
    chk_i (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .RX_VALID_OUT(RX_VALID_OUT), .TX_WORD_OUT(TX_WORD_OUT), .LINK_UP_OUT(LINK_UP_OUT),
    .AN_COMPLETE_OUT(AN_COMPLETE_OUT));

// ==== tb/serial_mac_model.sv ====
// Far-end transmitter model sending alternating comma and data groups into the deserializer side.
`timescale 1ns/1ps
module serial_mac_model (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // Stream shaping
    input  wire logic [3:0] shift_in,
    input  wire logic       inv_in,
    input  wire logic       rev_in,
    // Deserializer words
    output logic [9:0]      word_out
);
    logic [9:0]  prev_reg;
    logic [9:0]  cur_reg;
    logic [19:0] pair;
    logic [9:0]  raw;

    // The data group has no run of five equal bits, so only one word boundary holds a comma.
    always_ff @(posedge clk_in) begin
        if (reset_in) {prev_reg, cur_reg} <= {10'h2aa, 10'h0fa};
        else {prev_reg, cur_reg} <= {cur_reg, (cur_reg == 10'h0fa) ? 10'h2aa : 10'h0fa};
    end

    assign pair = {prev_reg, cur_reg} >> shift_in;
    assign raw = rev_in ? {<<{pair[9:0]}} : pair[9:0];
    assign word_out = inv_in ? ~raw : raw;
endmodule // serial_mac_model

// ==== tb/sgmii_pcs_lane_control_bench.sv ====
// Self-checking bench for the serial link coding control block.
`timescale 1ns/1ps
module sgmii_pcs_lane_control_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, perr, e, rx_valid, link_up, an_done;
    logic        txe = 1'b0;
    logic        txr = 1'b0;
    logic [9:0]  txc = 10'h0;
    logic [9:0]  rxw, rxc, txw, c0;
    logic [3:0]  sh = 4'h0;
    logic        inv = 1'b0;
    logic        rev = 1'b0;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          k;
    int          slips = 0;
    logic [15:0] txcfg [5] = '{16'h0203, 16'h0283, 16'h0213, 16'h0293, 16'h8203};
    logic [15:0] rxcfg [4] = '{16'h0263, 16'h0343, 16'h0203, 16'h0223};
    logic [3:0]  rxsh [4] = '{4'h0, 4'h3, 4'h0, 4'h0};
    int          tmr [4] = '{40, 250, 20, 60};

    always #4 clk = ~clk;

    serdes_link_ctrl #(.CYC_1600US(40), .CYC_800US(20), .CYC_11MS(60)) uut (
        .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(perr),
        .STRAP_LINK_EN_IN(1'b1), .RX_WORD_IN(rxw), .RX_CODE_OUT(rxc), .RX_VALID_OUT(rx_valid),
        .TX_CODE_IN(txc), .TX_EN_IN(txe), .TX_ERR_IN(txr), .TX_WORD_OUT(txw), .LINK_UP_OUT(link_up),
        .AN_COMPLETE_OUT(an_done));
    serial_mac_model mac (.clk_in(clk), .reset_in(rst), .shift_in(sh), .inv_in(inv), .rev_in(rev), .word_out(rxw));

    task summarize;
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ready and read data are taken at the rising edge that sees ready high, and only then is the request dropped.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
        r = prdata;
        e = perr;
        {psel, pen} <= 2'b00;
    endtask

    task wait_valid;
        for (k = 0; k < 300 && rx_valid !== 1'b1; k++) @(negedge clk);
        if (k == 300) begin
            n_mismatch++;
            summarize();
        end
    endtask

    function automatic logic [9:0] exp_tx(input logic [15:0] c, input logic er);
        logic [9:0] w;
        w = (er && !c[15]) ? serdes_link_pkg::ERR_CODE : 10'h1a5;
        if (c[4]) w = {<<{w}};
        return c[7] ? ~w : w;
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        apb(0, serdes_link_pkg::CTRL_ADDR, 0);
        chk(r, 32'h027b);
        apb(1, serdes_link_pkg::CTRL_ADDR, 32'hfdfe);
        apb(0, serdes_link_pkg::CTRL_ADDR, 0);
        chk(r, 32'hfdfe);
        apb(0, 12'h600, 0);
        chk({e, r[30:0]}, 32'h80000000);
        apb(0, serdes_link_pkg::RESTART_ADDR, 0);
        chk(r, 32'h0);
        for (int i = 0; i < 5; i++) for (int b = 0; b < 2; b++) begin
            apb(1, serdes_link_pkg::CTRL_ADDR, txcfg[i]);
            {txe, txr, txc} <= {1'b1, b[0], 10'h1a5};
            @(posedge clk);
            #1 chk(txw, exp_tx(txcfg[i], b[0]));
        end
        apb(1, serdes_link_pkg::CTRL_ADDR, 32'h020b);
        for (int t = 0; t < 2; t++) begin
            @(posedge clk);
            {txe, txr, txc} <= {1'b0, 1'b0, 10'h155};
            repeat (4 + t) @(posedge clk);
            {txe, txc} <= {1'b1, 10'h0cc};
            @(posedge clk);
            #1 slips += int'(txw !== 10'h0cc);
        end
        chk(slips, 1);
        apb(1, serdes_link_pkg::CTRL_ADDR, 32'h0003);
        repeat (3) @(posedge clk);
        #1 chk({rx_valid, txw}, 0);
        for (int i = 0; i < 4; i++) begin
            apb(1, serdes_link_pkg::CTRL_ADDR, 32'h0003);
            {sh, inv, rev} <= {rxsh[i], i == 1, i == 0 || i == 3};
            apb(1, serdes_link_pkg::CTRL_ADDR, rxcfg[i]);
            wait_valid();
            @(negedge clk);
            c0 = rxc;
            @(negedge clk);
            chk(c0 ^ rxc, 10'h0fa ^ 10'h2aa);
            apb(0, serdes_link_pkg::STATUS_ADDR, 0);
            chk(r[8:4], {1'b1, rxsh[i] == 0 ? 4'h0 : 4'ha - rxsh[i]});
        end
        apb(1, serdes_link_pkg::CTRL_ADDR, 32'h6343);
        apb(0, serdes_link_pkg::STATUS_ADDR, 0);
        chk(r[7:4], 4'h8);
        // The stream must match the inverted, unreversed receive setup used for negotiation.
        {sh, inv, rev} <= {4'h0, 1'b1, 1'b0};
        apb(1, serdes_link_pkg::CTRL_ADDR, 32'h0003);
        apb(1, serdes_link_pkg::CTRL_ADDR, 32'h0343);
        wait_valid();
        for (int c = 0; c < 4; c++) begin
            apb(1, serdes_link_pkg::CTRL_ADDR, 32'h0341 | (c << 1));
            apb(1, serdes_link_pkg::RESTART_ADDR, 32'h40);
            repeat (2) @(posedge clk);
            for (k = 0; k < 400 && an_done !== 1'b1; k++) @(negedge clk);
            chk(k >= tmr[c] - 4 && k <= tmr[c] + 8, 1);
            apb(0, serdes_link_pkg::STATUS_ADDR, 0);
            chk(r[11:10], 2'b11);
        end
        apb(1, serdes_link_pkg::CTRL_ADDR, 32'h0340);
        apb(1, serdes_link_pkg::RESTART_ADDR, 32'h40);
        repeat (10) @(posedge clk);
        #1 chk({link_up, an_done}, 2'b10);
        summarize();
    end
endmodule // sgmii_pcs_lane_control_bench
